//--- common/din_monitor_consts.svh
// Register offsets, field positions, reset values and timing counts of the input monitor
`ifndef DIN_MONITOR_CONSTS_SVH
`define DIN_MONITOR_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_CFG_ONE      5'h00
`define ADDR_CFG_TWO      5'h04
`define ADDR_AUX_SETUP    5'h08
`define ADDR_ALERT        5'h0C
`define ADDR_RESULT       5'h10
`define ADDR_COUNT        5'h14
`define ADDR_FUNC_SEL     5'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG1_DEB_TIME_LSB  0
`define CFG1_DEB_MODE_BIT  5
`define CFG1_SINK_RNG_BIT  6
`define CFG1_SINK_LSB      7
`define CFG1_INVERT_BIT    12
`define CFG1_CNT_EN_BIT    13
`define CFG2_THR_LSB       0
`define CFG2_THR_REF_BIT   7
`define CFG2_BYPASS_BIT    8
`define CFG2_OW_EN_BIT     9
`define CFG2_SW_EN_BIT     10
`define AUX_DRIVE_BIT      0
`define FUNC_FOUR_WIRE_BIT 0
`define FUNC_CONV_EN_BIT   1
`define FUNC_DIN_EN_BIT    2
`define ALERT_RTD_OPEN_BIT 0
`define ALERT_DIN_OPEN_BIT 1
`define ALERT_DIN_SHORT_BIT 2

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CFG_ONE_RST   14'h0000
`define CFG_TWO_RST   11'h000
`define AUX_RST       1'h0
`define FUNC_RST      3'h0
`define THRESH_MAX    7'h62

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    100
`define SAMPLE_PERIOD_NS 800
`define SAMPLE_CYCLES    (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

//--- common/din_monitor_pkg.sv
// Types shared by the digital input monitor
`default_nettype none
package din_monitor_pkg;

	// Levels arriving from the analog front end
	typedef struct packed {
		logic compBuffered;
		logic compUnbuffered;
		logic excitationSenseHigh;
		logic openWireDetect;
		logic shortDetect;
	} senseIn_s;

	// Settings driven to the analog front end
	typedef struct packed {
		logic [6:0] thresholdCode;
		logic       thresholdRefSelect;
		logic       inputBufferBypass;
		logic       sinkRange;
		logic [4:0] sinkCode;
		logic       openWireCheckEnable;
		logic       extraSinkEnable;
		logic       converterEnable;
	} anaCtrl_s;

endpackage : din_monitor_pkg
`default_nettype wire

//--- hw/digital_input_monitor.sv
// Digital input conditioning, edge counter and fault flags behind an Avalon-MM slave
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "din_monitor_consts.svh"

// Functional notes
// - Four-wire mode: sense high sets open flag
// - Bypass bit routes unbuffered comparator input
// - Result readable; aux pin drives debounced signal
// - Converter stays usable during digital input
// - Reference select bit picks threshold reference
// - Threshold code seven bits, max 98
// - Supply reference: threshold scales (code-48)/50
// - Fixed reference: threshold scales (code-38)/5
// - Sink set by range bit and code
// - Open-wire check flags low current
// - Short check adds sink, flags overload
// - Any fault sets status and alert pin
// - Invert bit inverts result, else passes
// - Counter counts result edges, inverter picks
// - Reset clears edge counter
// - Counter wraps to zero past full scale
// - Count enable in config one, count readable
// - Cleared enable holds the count
// - Five-bit debounce time, zero bypasses
module digital_input_monitor
	import din_monitor_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [4:0]   address,
	input  wire logic         read,
	input  wire logic         write,
	input  wire logic [31:0]  writedata,
	input  wire logic [3:0]   byteenable,
	output logic      [31:0]  readdata,
	output logic              waitrequest,
	input  wire senseIn_s     senseIn,
	output anaCtrl_s          anaCtrl,
	output logic              auxPinOut,
	output logic              auxPinOe,
	output logic              alertPin
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                rstMeta_r, rstSync_r;
	senseIn_s            senseMeta_r, senseSync_r;
	logic                waitReq_r;
	logic [31:0]         readData_r;
	logic [13:0]         cfgOne_r;
	logic [10:0]         cfgTwo_r;
	logic [0:0]          auxSetup_r;
	logic [2:0]          funcSel_r;
	logic [2:0]          alert_r, alertNxt, alertSet, alertClr;
	logic [2:0]          tickCnt_r;
	logic                tick;
	logic [16:0]         debCnt_r;
	logic                debounced_r, result_r, resultPrev_r;
	logic [COUNT_W-1:0]  count_r;
	anaCtrl_s            anaCtrl_r;
	logic                auxOut_r, auxOe_r, alertPin_r;
	logic                wrEn, compSel;
	logic [4:0]          debTime;

	localparam logic [2:0] SAMPLE_LAST = 3'(`SAMPLE_CYCLES - 1);

	// Debounce target in samples of the comparator
	function automatic logic [16:0] debTarget(input logic [4:0] code);
		unique case (code)
			5'h00: debTarget = 17'h00000;
			5'h01: debTarget = 17'h00010;
			5'h02: debTarget = 17'h00017;
			5'h03: debTarget = 17'h0001E;
			5'h04: debTarget = 17'h00028;
			5'h05: debTarget = 17'h00034;
			5'h06: debTarget = 17'h00046;
			5'h07: debTarget = 17'h0005E;
			5'h08: debTarget = 17'h0007E;
			5'h09: debTarget = 17'h000A2;
			5'h0A: debTarget = 17'h000E1;
			5'h0B: debTarget = 17'h0012C;
			5'h0C: debTarget = 17'h00190;
			5'h0D: debTarget = 17'h0020D;
			5'h0E: debTarget = 17'h002BC;
			5'h0F: debTarget = 17'h003AA;
			5'h10: debTarget = 17'h004E3;
			5'h11: debTarget = 17'h0065A;
			5'h12: debTarget = 17'h008CB;
			5'h13: debTarget = 17'h00BB9;
			5'h14: debTarget = 17'h00FA1;
			5'h15: debTarget = 17'h01483;
			5'h16: debTarget = 17'h01B59;
			5'h17: debTarget = 17'h0249F;
			5'h18: debTarget = 17'h030D4;
			5'h19: debTarget = 17'h03F7A;
			5'h1A: debTarget = 17'h057E4;
			5'h1B: debTarget = 17'h07530;
			5'h1C: debTarget = 17'h09C40;
			5'h1D: debTarget = 17'h0CD14;
			5'h1E: debTarget = 17'h11170;
			5'h1F: debTarget = 17'h16E36;
		endcase
	endfunction : debTarget
	// Merge write data into a register under byte enables
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			laneMerge[8*i +: 8] = be[i] ? data[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : laneMerge

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_r);

	// ----------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------
	// Release reset through two flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// Front-end levels pass two flip-flops
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			senseMeta_r <= '0;
			senseSync_r <= '0;
		end else begin
			senseMeta_r <= senseIn;
			senseSync_r <= senseMeta_r;
		end
	end

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// A request sees one wait cycle, then completes
	assign wrEn = write && !waitReq_r;
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			waitReq_r <= 1'b1;
		end else begin
			waitReq_r <= !((read || write) && waitReq_r);
		end
	end

	// Read data latched while waitrequest is high; reads change nothing
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			readData_r <= 32'h00000000;
		end else if (read && waitReq_r) begin
			unique case (address)
				`ADDR_CFG_ONE:   readData_r <= {18'h00000, cfgOne_r};
				`ADDR_CFG_TWO:   readData_r <= {21'h000000, cfgTwo_r};
				`ADDR_AUX_SETUP: readData_r <= {31'h00000000, auxSetup_r};
				`ADDR_ALERT:     readData_r <= {29'h00000000, alert_r};
				`ADDR_RESULT:    readData_r <= {31'h00000000, result_r};
				`ADDR_COUNT:     readData_r <= 32'(count_r);
				`ADDR_FUNC_SEL:  readData_r <= {29'h00000000, funcSel_r};
				default:         readData_r <= 32'h00000000;
			endcase
		end
	end

	// Writable configuration; result and count take no writes
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cfgOne_r   <= `CFG_ONE_RST;
			cfgTwo_r   <= `CFG_TWO_RST;
			auxSetup_r <= `AUX_RST;
			funcSel_r  <= `FUNC_RST;
		end else if (wrEn) begin
			unique case (address)
				`ADDR_CFG_ONE:   cfgOne_r <= 14'(laneMerge(32'(cfgOne_r), writedata, byteenable));
				`ADDR_CFG_TWO:   cfgTwo_r <= 11'(laneMerge(32'(cfgTwo_r), writedata, byteenable));
				`ADDR_AUX_SETUP: auxSetup_r <= byteenable[0] ? writedata[0:0] : auxSetup_r;
				`ADDR_FUNC_SEL:  funcSel_r <= byteenable[0] ? writedata[2:0] : funcSel_r;
				default: ;
			endcase
		end
	end
	a_wait_release: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("waitrequest did not drop after one cycle");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest stayed low two cycles");

	// ----------------------------------------
	// Comparator sampling and debounce
	// ----------------------------------------
	assign debTime = cfgOne_r[`CFG1_DEB_TIME_LSB +: 5];
	assign compSel = cfgTwo_r[`CFG2_BYPASS_BIT] ? senseSync_r.compUnbuffered
	                                            : senseSync_r.compBuffered;
	// Sample tick every sample period
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			tickCnt_r <= 3'h0;
		end else begin
			tickCnt_r <= (tickCnt_r == SAMPLE_LAST) ? 3'h0 : tickCnt_r + 3'h1;
		end
	end
	assign tick = (tickCnt_r == SAMPLE_LAST);

	// Mode 0 counts up and down, mode 1 restarts on return
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			debCnt_r    <= 17'h00000;
			debounced_r <= 1'b0;
		end else if (debTime == 5'h00) begin
			debCnt_r    <= 17'h00000;
			debounced_r <= compSel;
		end else if (tick) begin
			if (compSel != debounced_r) begin
				if (debCnt_r + 17'h00001 >= debTarget(debTime)) begin
					debCnt_r    <= 17'h00000;
					debounced_r <= compSel;
				end else begin
					debCnt_r <= debCnt_r + 17'h00001;
				end
			end else if (cfgOne_r[`CFG1_DEB_MODE_BIT]) begin
				debCnt_r <= 17'h00000;
			end else if (debCnt_r != 17'h00000) begin
				debCnt_r <= debCnt_r - 17'h00001;
			end
		end
	end
	a_bypass_follow: assert property (debTime == 5'h00 |=> debounced_r == $past(compSel))
		else $error("bypassed debounce did not follow comparator");
	a_bypass_route: assert property ((debTime == 5'h00) && cfgTwo_r[`CFG2_BYPASS_BIT]
		|=> debounced_r == $past(senseSync_r.compUnbuffered))
		else $error("buffer bypass did not select unbuffered input");

	// ----------------------------------------
	// Result, inverter and edge counter
	// ----------------------------------------
	// Result register, optionally inverted
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			result_r     <= 1'b0;
			resultPrev_r <= 1'b0;
		end else begin
			result_r     <= debounced_r ^ cfgOne_r[`CFG1_INVERT_BIT];
			resultPrev_r <= result_r;
		end
	end
	// Rising result edge is a debounced edge picked by the inverter
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			count_r <= '0;
		end else if (cfgOne_r[`CFG1_CNT_EN_BIT] && result_r && !resultPrev_r) begin
			count_r <= count_r + 1'b1;
		end
	end
	a_result_invert: assert property (1'b1 |=>
		result_r == ($past(debounced_r) ^ $past(cfgOne_r[`CFG1_INVERT_BIT])))
		else $error("result does not match inverter setting");
	a_count_hold: assert property (!cfgOne_r[`CFG1_CNT_EN_BIT] |=> $stable(count_r))
		else $error("count moved while disabled");
	a_count_step: assert property (cfgOne_r[`CFG1_CNT_EN_BIT] && result_r && !resultPrev_r
		|=> count_r == COUNT_W'($past(count_r) + 1'b1))
		else $error("count did not advance on edge");

	// ----------------------------------------
	// Fault flags and alert pin
	// ----------------------------------------
	always_comb begin
		alertSet = 3'h0;
		alertSet[`ALERT_RTD_OPEN_BIT]  = funcSel_r[`FUNC_FOUR_WIRE_BIT]
		                                 && senseSync_r.excitationSenseHigh;
		alertSet[`ALERT_DIN_OPEN_BIT]  = cfgTwo_r[`CFG2_OW_EN_BIT]
		                                 && senseSync_r.openWireDetect;
		alertSet[`ALERT_DIN_SHORT_BIT] = cfgTwo_r[`CFG2_SW_EN_BIT]
		                                 && senseSync_r.shortDetect;
		alertClr = (wrEn && address == `ADDR_ALERT && byteenable[0]) ? writedata[2:0] : 3'h0;
		alertNxt = (alert_r & ~alertClr) | alertSet;
	end
	// Sticky flags, write one to clear, a new fault wins
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			alert_r    <= 3'h0;
			alertPin_r <= 1'b0;
		end else begin
			alert_r    <= alertNxt;
			alertPin_r <= |alertNxt;
		end
	end
	sequence owEvent;
		cfgTwo_r[`CFG2_OW_EN_BIT] && senseSync_r.openWireDetect;
	endsequence
	sequence swEvent;
		cfgTwo_r[`CFG2_SW_EN_BIT] && senseSync_r.shortDetect;
	endsequence
	sequence rtdEvent;
		funcSel_r[`FUNC_FOUR_WIRE_BIT] && senseSync_r.excitationSenseHigh;
	endsequence
	sequence alertShown(int b);
		alert_r[b] && alertPin;
	endsequence
	a_open_flag: assert property (owEvent |=> alertShown(`ALERT_DIN_OPEN_BIT))
		else $error("open wire fault not flagged");
	a_short_flag: assert property (swEvent |=> alertShown(`ALERT_DIN_SHORT_BIT))
		else $error("short fault not flagged");
	a_rtd_open: assert property (rtdEvent |=> alertShown(`ALERT_RTD_OPEN_BIT))
		else $error("four-wire open circuit not flagged");
	a_alert_quiet: assert property (alert_r == 3'h0 && alertSet == 3'h0 |=> !alertPin)
		else $error("alert pin set with no fault");

	// ----------------------------------------
	// Front-end settings and auxiliary pin
	// ----------------------------------------
	// Threshold code is held at or below its maximum
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			anaCtrl_r <= '0;
		end else begin
			anaCtrl_r.thresholdCode <= (cfgTwo_r[`CFG2_THR_LSB +: 7] > `THRESH_MAX)
			                           ? `THRESH_MAX : cfgTwo_r[`CFG2_THR_LSB +: 7];
			anaCtrl_r.thresholdRefSelect  <= cfgTwo_r[`CFG2_THR_REF_BIT];
			anaCtrl_r.inputBufferBypass   <= cfgTwo_r[`CFG2_BYPASS_BIT];
			anaCtrl_r.sinkRange           <= cfgOne_r[`CFG1_SINK_RNG_BIT];
			anaCtrl_r.sinkCode            <= cfgOne_r[`CFG1_SINK_LSB +: 5];
			anaCtrl_r.openWireCheckEnable <= cfgTwo_r[`CFG2_OW_EN_BIT];
			anaCtrl_r.extraSinkEnable     <= cfgTwo_r[`CFG2_SW_EN_BIT];
			anaCtrl_r.converterEnable     <= funcSel_r[`FUNC_CONV_EN_BIT];
		end
	end
	// Aux pin carries the debounced signal when selected
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			auxOut_r <= 1'b0;
			auxOe_r  <= 1'b0;
		end else begin
			auxOe_r  <= auxSetup_r[`AUX_DRIVE_BIT];
			auxOut_r <= auxSetup_r[`AUX_DRIVE_BIT] && debounced_r;
		end
	end
	a_thresh_clamp: assert property (anaCtrl.thresholdCode <= `THRESH_MAX)
		else $error("threshold code above maximum");
	a_conv_kept: assert property (funcSel_r[`FUNC_CONV_EN_BIT] |=> anaCtrl.converterEnable)
		else $error("converter enable lost");
	a_aux_drive: assert property (auxSetup_r[`AUX_DRIVE_BIT]
		|=> auxPinOe && auxPinOut == $past(debounced_r))
		else $error("aux pin not driving debounced input");
	assign readdata    = readData_r;
	assign waitrequest = waitReq_r;
	assign anaCtrl     = anaCtrl_r;
	assign auxPinOut   = auxOut_r;
	assign auxPinOe    = auxOe_r;
	assign alertPin    = alertPin_r;

endmodule : digital_input_monitor
`default_nettype wire

//--- verification/field_sensor_model.sv
// Field sensor model driving comparator and fault levels
`timescale 1ns/1ns
`default_nettype none
module field_sensor_model
	import din_monitor_pkg::*;
(
	input  wire logic clk,
	output var senseIn_s senseIn
);
	// Front end starts quiet
	initial senseIn = '0;

	// Buffered and raw comparator levels, changed after an edge
	task automatic setComp(input logic b, input logic u);
		@(posedge clk);
		senseIn.compBuffered   <= b;
		senseIn.compUnbuffered <= u;
	endtask : setComp

	// Sense-high, open-wire and short detector levels
	task automatic setFault(input logic s, input logic o, input logic h);
		@(posedge clk);
		senseIn.excitationSenseHigh <= s;
		senseIn.openWireDetect      <= o;
		senseIn.shortDetect         <= h;
	endtask : setFault

	// Square wave of n periods, each half period lasting half plus one clocks
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			setComp(1'b1, 1'b1);
			repeat (half) @(posedge clk);
			setComp(1'b0, 1'b0);
			repeat (half) @(posedge clk);
		end
	endtask : pulses
endmodule : field_sensor_model
`default_nettype wire

//--- verification/digital_input_monitor_tb_top.sv
// Self-checking bench of the digital input monitor
`timescale 1ns/1ns
`default_nettype none
`include "din_monitor_consts.svh"
module digital_input_monitor_tb_top import din_monitor_pkg::*; ;
	localparam int CW   = 3;
	localparam int FULL = 1 << CW;
	logic        clk;
	logic        rst_n;
	logic [4:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	senseIn_s    senseIn;
	anaCtrl_s    anaCtrl;
	logic        auxPinOut;
	logic        auxPinOe;
	logic        alertPin;
	int          fail_count;
	int          n_tests;

	// Block under test with a narrow counter so wrap is cheap
	digital_input_monitor #(.COUNT_W(CW)) digital_input_monitor_inst (
		.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .senseIn(senseIn),
		.anaCtrl(anaCtrl), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
		.alertPin(alertPin)
	);

	// Field sensor on the terminal side
	field_sensor_model field_sensor_model_inst (.clk(clk), .senseIn(senseIn));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Verdict and end of run
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
			fail_count++;
		end
	endtask : check

	task automatic chkBit(input string nm, input logic e, input logic g);
		check(nm, 32'(e), 32'(g));
	endtask : chkBit

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic busCycle(input logic [4:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, input logic [3:0] be);
		int i;
		@(posedge clk);
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		if (w) write <= 1'b1;
		else read <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		if (i == 20) begin
			$display("[FAIL] waitrequest expected 0 seen 1");
			fail_count++;
			conclude();
		end
	endtask : busCycle

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		busCycle(a, 1'b1, d, q, 4'hF);
	endtask : wr

	task automatic rdChk(input logic [4:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		busCycle(a, 1'b0, 32'h0000_0000, q, 4'hF);
		check(nm, e, q);
	endtask : rdChk

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask : waitClk

	// Reset held 8 cycles, outputs quiet meanwhile
	task automatic doReset();
		@(posedge clk);
		rst_n <= 1'b0;
		waitClk(8);
		chkBit("waitrequest in reset", 1'b1, waitrequest);
		chkBit("alert in reset", 1'b0, alertPin);
		rst_n <= 1'b1;
		waitClk(4);
		rdChk(`ADDR_COUNT, 32'h0000_0000, "count after reset");
	endtask : doReset

	task automatic scnConfig();
		logic [31:0] q;
		rdChk(`ADDR_CFG_ONE, 32'h0000_0000, "cfg one reset");
		wr(`ADDR_CFG_ONE, 32'h0000_0A00);
		wr(`ADDR_CFG_TWO, 32'h0000_00B7);
		waitClk(2);
		check("sink code", 32'h14, 32'(anaCtrl.sinkCode));
		check("thr code", 32'h37, 32'(anaCtrl.thresholdCode));
		chkBit("thr ref", 1'b1, anaCtrl.thresholdRefSelect);
		wr(`ADDR_CFG_ONE, 32'h0000_0EC0);
		wr(`ADDR_CFG_TWO, 32'h0000_0130);
		waitClk(2);
		chkBit("sink range", 1'b1, anaCtrl.sinkRange);
		check("sink code", 32'h1D, 32'(anaCtrl.sinkCode));
		chkBit("supply ref", 1'b0, anaCtrl.thresholdRefSelect);
		check("supply code", 32'h30, 32'(anaCtrl.thresholdCode));
		chkBit("bypass", 1'b1, anaCtrl.inputBufferBypass);
		wr(`ADDR_CFG_TWO, 32'h0000_007F);
		waitClk(2);
		check("thr clamp", 32'h62, 32'(anaCtrl.thresholdCode));
		rdChk(`ADDR_CFG_TWO, 32'h0000_007F, "cfg two");
		wr(`ADDR_FUNC_SEL, 32'h0000_0006);
		waitClk(2);
		chkBit("converter", 1'b1, anaCtrl.converterEnable);
		rdChk(`ADDR_FUNC_SEL, 32'h0000_0006, "func sel");
		rdChk(5'h1C, 32'h0000_0000, "unmapped");
		// Only lane 0 enabled: upper byte must keep its old value
		busCycle(`ADDR_CFG_ONE, 1'b1, 32'h0000_3F00, q, 4'h1);
		rdChk(`ADDR_CFG_ONE, 32'h0000_0E00, "lane mask");
	endtask : scnConfig

	task automatic scnPath();
		wr(`ADDR_CFG_ONE, 32'h0000_0000);
		wr(`ADDR_CFG_TWO, 32'h0000_0000);
		wr(`ADDR_AUX_SETUP, 32'h0000_0001);
		field_sensor_model_inst.setComp(1'b1, 1'b0);
		waitClk(10);
		rdChk(`ADDR_RESULT, 32'h0000_0001, "result buffered");
		chkBit("aux oe", 1'b1, auxPinOe);
		chkBit("aux out", 1'b1, auxPinOut);
		wr(`ADDR_CFG_TWO, 32'h0000_0100);
		waitClk(10);
		rdChk(`ADDR_RESULT, 32'h0000_0000, "result raw");
		chkBit("aux out raw", 1'b0, auxPinOut);
		wr(`ADDR_CFG_ONE, 32'h0000_1000);
		waitClk(10);
		rdChk(`ADDR_RESULT, 32'h0000_0001, "result inverted");
		chkBit("aux not inverted", 1'b0, auxPinOut);
		wr(`ADDR_CFG_TWO, 32'h0000_0000);
		wr(`ADDR_CFG_ONE, 32'h0000_0001);
		field_sensor_model_inst.setComp(1'b0, 1'b0);
		waitClk(60);
		rdChk(`ADDR_RESULT, 32'h0000_0001, "debounce early");
		waitClk(200);
		rdChk(`ADDR_RESULT, 32'h0000_0000, "debounce done");
		// Mode 1: a glitch restarts the full wait
		wr(`ADDR_CFG_ONE, 32'h0000_0021);
		field_sensor_model_inst.setComp(1'b1, 1'b1);
		waitClk(60);
		field_sensor_model_inst.setComp(1'b0, 1'b0);
		waitClk(8);
		field_sensor_model_inst.setComp(1'b1, 1'b1);
		waitClk(100);
		rdChk(`ADDR_RESULT, 32'h0000_0000, "mode1 restart");
		waitClk(60);
		rdChk(`ADDR_RESULT, 32'h0000_0001, "mode1 done");
	endtask : scnPath

	task automatic scnCount();
		wr(`ADDR_CFG_ONE, 32'h0000_0000);
		wr(`ADDR_AUX_SETUP, 32'h0000_0000);
		field_sensor_model_inst.setComp(1'b0, 1'b0);
		waitClk(10);
		chkBit("aux released", 1'b0, auxPinOe);
		wr(`ADDR_CFG_ONE, 32'h0000_2000);
		field_sensor_model_inst.pulses(5, 12);
		rdChk(`ADDR_COUNT, 32'(5 % FULL), "count rising");
		wr(`ADDR_CFG_ONE, 32'h0000_0000);
		field_sensor_model_inst.pulses(3, 12);
		rdChk(`ADDR_COUNT, 32'(5 % FULL), "count held");
		wr(`ADDR_CFG_ONE, 32'h0000_2000);
		field_sensor_model_inst.pulses(4, 12);
		rdChk(`ADDR_COUNT, 32'(9 % FULL), "count wrap");
		wr(`ADDR_CFG_ONE, 32'h0000_1000);
		waitClk(10);
		wr(`ADDR_CFG_ONE, 32'h0000_3000);
		field_sensor_model_inst.pulses(2, 12);
		rdChk(`ADDR_COUNT, 32'(11 % FULL), "count falling");
		wr(`ADDR_COUNT, 32'h0000_0000);
		wr(`ADDR_RESULT, 32'h0000_0000);
		rdChk(`ADDR_COUNT, 32'(11 % FULL), "count read-only");
		rdChk(`ADDR_RESULT, 32'h0000_0001, "result read-only");
	endtask : scnCount

	task automatic scnFault();
		wr(`ADDR_CFG_ONE, 32'h0000_0780);
		wr(`ADDR_CFG_TWO, 32'h0000_06B7);
		waitClk(2);
		chkBit("extra sink", 1'b1, anaCtrl.extraSinkEnable);
		chkBit("open check", 1'b1, anaCtrl.openWireCheckEnable);
		field_sensor_model_inst.setFault(1'b1, 1'b0, 1'b0);
		waitClk(10);
		rdChk(`ADDR_ALERT, 32'h0000_0000, "no four-wire");
		chkBit("alert idle", 1'b0, alertPin);
		wr(`ADDR_FUNC_SEL, 32'h0000_0001);
		waitClk(5);
		chkBit("converter off", 1'b0, anaCtrl.converterEnable);
		rdChk(`ADDR_ALERT, 32'h0000_0001, "four-wire open");
		chkBit("alert pin", 1'b1, alertPin);
		field_sensor_model_inst.setFault(1'b0, 1'b1, 1'b1);
		wr(`ADDR_FUNC_SEL, 32'h0000_0000);
		waitClk(6);
		rdChk(`ADDR_ALERT, 32'h0000_0007, "open and short");
		rdChk(`ADDR_ALERT, 32'h0000_0007, "read harmless");
		field_sensor_model_inst.setFault(1'b0, 1'b0, 1'b0);
		waitClk(5);
		wr(`ADDR_ALERT, 32'h0000_0007);
		waitClk(2);
		rdChk(`ADDR_ALERT, 32'h0000_0000, "alert cleared");
		chkBit("alert pin low", 1'b0, alertPin);
		wr(`ADDR_CFG_TWO, 32'h0000_00B7);
		field_sensor_model_inst.setFault(1'b0, 1'b1, 1'b1);
		waitClk(8);
		rdChk(`ADDR_ALERT, 32'h0000_0000, "checks disabled");
		field_sensor_model_inst.setFault(1'b0, 1'b0, 1'b0);
	endtask : scnFault

	// Main sequence, ending with a reset in mid-run
	initial begin
		fail_count = 0;
		n_tests    = 0;
		rst_n      = 1'b0;
		read       = 1'b0;
		write      = 1'b0;
		address    = '0;
		writedata  = '0;
		byteenable = '0;
		doReset();
		scnConfig();
		scnPath();
		scnCount();
		scnFault();
		doReset();
		conclude();
	end
endmodule : digital_input_monitor_tb_top
`default_nettype wire
